/* File: tsw_cfg.svh */
`ifndef TSW_CFG_SVH
`define TSW_CFG_SVH

// clock and time base
`define TSW_CLK_MHZ        100
`define TSW_TICK_US        1000
`define TSW_TICK_CYCLES    (`TSW_CLK_MHZ * `TSW_TICK_US)
`define TSW_TCONV_MS       8'h1C
`define TSW_TIMEOUT_MS     32'h19

// reset values
`define TSW_CONF_RST       5'h00
`define TSW_TOS_RST        9'h0A0
`define TSW_THYST_RST      9'h096
`define TSW_TIDLE_RST      8'h64
`define TSW_TEMP_RST       11'h000
`define TSW_TARGET_BASE    7'h40

// register byte addresses
`define TSW_OFF_TEMP       8'h00
`define TSW_OFF_CONF       8'h04
`define TSW_OFF_THYST      8'h08
`define TSW_OFF_TOS        8'h0C
`define TSW_OFF_TIDLE      8'h10
`define TSW_OFF_STATUS     8'h14

// configuration fields
`define TSW_CONF_SHDN      0
`define TSW_CONF_ALMMODE   1
`define TSW_CONF_POL       2
`define TSW_CONF_FQ_LO     3
`define TSW_CONF_FQ_HI     4

// layouts: temp in [15:5], set points in [15:7]
`define TSW_TEMP_LSB       5
`define TSW_SETP_LSB       7

// status fields
`define TSW_ST_ADDR_HI     6
`define TSW_ST_ALARM       8
`define TSW_ST_BUSY        9
`define TSW_ST_NEW         10
`define TSW_ST_TIMEOUT     11

// fault queue depths per setting
`define TSW_FQ_0           3'h1
`define TSW_FQ_1           3'h2
`define TSW_FQ_2           3'h4
`define TSW_FQ_3           3'h6

`endif

/* File: tsw_pkg.sv */
package tsw_pkg;
  typedef enum logic [2:0] {
    CV_IDLE = 3'b001,
    CV_RUN  = 3'b010,
    CV_WAIT = 3'b100
  } tsw_conv_st_t;
  typedef logic        [10:0] tsw_temp_t;
  typedef logic signed [8:0]  tsw_setp_t;
endpackage : tsw_pkg

/* File: tsw_cmp_if.sv */
interface tsw_cmp_if;
  import tsw_pkg::*;
  tsw_setp_t  temp9;
  tsw_setp_t  tos;
  tsw_setp_t  thyst;
  logic       int_mode;
  logic [1:0] fq_sel;
  logic       cmp_stb;
  logic       rd_stb;
  logic       shdn_stb;
  modport ctl (output temp9, tos, thyst, int_mode, fq_sel, cmp_stb, rd_stb, shdn_stb);
  modport alm (input temp9, tos, thyst, int_mode, fq_sel, cmp_stb, rd_stb, shdn_stb);
endinterface : tsw_cmp_if

/* File: tsw_conv.sv */
`include "tsw_cfg.svh"
module tsw_conv
  import tsw_pkg::*;
(
  input  wire logic      clk_sys_in,
  input  wire logic      rst_in,
  input  wire logic      ms_tick_in,
  input  wire logic      shutdown_in,
  input  wire logic [7:0] period_ms_in,
  input  wire tsw_temp_t adc_result_in,
  output tsw_temp_t      temp_out,
  output logic           done_out,
  output logic           busy_out
);
  tsw_conv_st_t st_q;
  tsw_conv_st_t st_d;
  logic [7:0]   cnt_q;
  logic [7:0]   cnt_d;
  tsw_temp_t    temp_q;
  logic         done_d;
  logic         done_q;
  wire          conv_end = (cnt_q == `TSW_TCONV_MS - 8'h01) & ms_tick_in;
  wire          per_end  = ((cnt_q + 8'h01) >= period_ms_in) & ms_tick_in;

  // bus traffic never reaches this timer, so it cannot stall a conversion
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    case (st_q)
      CV_IDLE: begin
        cnt_d = 8'h00;
        if (!shutdown_in) st_d = CV_RUN;
      end
      CV_RUN: begin
        // shutdown lets a running conversion finish
        if (conv_end) begin
          done_d = 1'b1;
          st_d   = CV_WAIT;
          cnt_d  = cnt_q + 8'h01;
        end else if (ms_tick_in) begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      CV_WAIT: begin
        if (shutdown_in) begin
          st_d = CV_IDLE;
        end else if (per_end) begin
          st_d  = CV_RUN;
          cnt_d = 8'h00;
        end else if (ms_tick_in) begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      default: st_d = CV_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q   <= CV_IDLE;
      cnt_q  <= 8'h00;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  // result lands unconditionally, whatever the bus is doing
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) temp_q <= `TSW_TEMP_RST;
    else if (done_d) temp_q <= adc_result_in;
  end

  assign temp_out = temp_q;
  assign done_out = done_q;
  assign busy_out = (st_q == CV_RUN);
endmodule : tsw_conv

/* File: tsw_alarm.sv */
`include "tsw_cfg.svh"
module tsw_alarm
  import tsw_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  tsw_cmp_if.alm    cmp,
  output logic      active_out
);
  logic [2:0] fcnt_q;
  logic       active_q;
  logic       expect_hi_q;
  logic [2:0] depth;
  logic       fault;

  always_comb begin
    case (cmp.fq_sel)
      2'b00:   depth = `TSW_FQ_0;
      2'b01:   depth = `TSW_FQ_1;
      2'b10:   depth = `TSW_FQ_2;
      default: depth = `TSW_FQ_3;
    endcase
  end

  wire over  = cmp.temp9 > cmp.tos;
  wire under = cmp.temp9 < cmp.thyst;
  // comparator watches for the opposite edge of its state; interrupt alternates
  wire look_hi = cmp.int_mode ? expect_hi_q : ~active_q;
  assign fault = look_hi ? over : under;
  wire trip = cmp.cmp_stb & fault & ((fcnt_q + 3'h1) >= depth);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) fcnt_q <= 3'h0;
    else if (cmp.cmp_stb) fcnt_q <= (fault & ~trip) ? fcnt_q + 3'h1 : 3'h0;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      active_q    <= 1'b0;
      expect_hi_q <= 1'b1;
    end else if (!cmp.int_mode) begin
      expect_hi_q <= 1'b1;
      if (trip) active_q <= ~active_q;
    end else if (trip) begin
      // set wins over a read or shutdown in the same cycle
      active_q    <= 1'b1;
      expect_hi_q <= ~expect_hi_q;
    end else if (cmp.rd_stb | cmp.shdn_stb) begin
      active_q <= 1'b0;
    end
  end

  assign active_out = active_q;
endmodule : tsw_alarm

/* File: tsw_top.sv */
// What this block does
// - temperature result held as 11-bit two's complement, lsb 0.125 degrees
// - bus accesses never stall or abort a running conversion
// - continuous bus traffic never blocks storing a finished result
// - a new result is readable the cycle after it is stored
// - reading just one byte of temperature is safe and harmless
// - alarm pin goes active when temperature passes programmed limits
// - alarm runs in comparator or interrupt mode, chosen by configuration
// - alarm active level is programmable high or low
// - alarm trips after programmed consecutive faults; queue and limits writable
// - normal mode converts periodically; shutdown stops conversions
// - reset gives normal mode, comparator, limits 80 and 75 degrees
// - target address decoded from three three-state address pins, 27 codes
// - bus access bounded; stalled transfer flagged after a time-out
// - set points rewritable at run time, effective without reset
// - registers: configuration, temperature, two set points, sampling interval
// - config bits: shutdown, alarm mode, polarity, two fault queue bits
// - set points 9-bit signed; compare uses top nine temperature bits
// - comparator: set above upper, clear below hysteresis; reads don't affect
// - interrupt: held until any read; trips alternate; shutdown clears
//
// The APB register port and the placing of the registers were chosen for this implementation.
`include "tsw_cfg.svh"
module tsw_top
  import tsw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TSW_TICK_CYCLES,
  parameter int unsigned TIMEOUT_MS  = `TSW_TIMEOUT_MS
)(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [10:0] adc_result_in,
  input  wire logic [1:0]  addr_pin_0_in,
  input  wire logic [1:0]  addr_pin_1_in,
  input  wire logic [1:0]  addr_pin_2_in,
  output logic [6:0]       target_addr_out,
  output logic             overtemp_alarm_out,
  output logic             overtemp_alarm_oe_n_out
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // time base: one-cycle pulse per millisecond
  logic [TW-1:0] tick_cnt_q;
  logic          ms_tick_q;
  wire           tick_wrap = (tick_cnt_q == TW'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tick_cnt_q <= '0;
      ms_tick_q  <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 1'b1;
      ms_tick_q  <= tick_wrap;
    end
  end

  // registers
  logic [4:0]  conf_q;
  tsw_setp_t   tos_q;
  tsw_setp_t   thyst_q;
  logic [7:0]  tidle_q;
  logic        new_q;
  logic        tmo_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  tsw_temp_t   temp;
  logic        conv_done;
  logic        conv_busy;
  logic        alarm_act;

  // apb decode; one wait state, completion at the edge that sees pready
  wire acc      = psel_in & penable_in;
  wire acc_1st  = acc & ~pready_q;
  wire fin      = acc & pready_q;
  wire hit_temp = (paddr_in == `TSW_OFF_TEMP);
  wire hit_conf = (paddr_in == `TSW_OFF_CONF);
  wire hit_thys = (paddr_in == `TSW_OFF_THYST);
  wire hit_tos  = (paddr_in == `TSW_OFF_TOS);
  wire hit_tidl = (paddr_in == `TSW_OFF_TIDLE);
  wire hit_stat = (paddr_in == `TSW_OFF_STATUS);
  wire hit      = hit_temp | hit_conf | hit_thys | hit_tos | hit_tidl | hit_stat;
  wire wr_ok    = fin & pwrite_in & hit;
  wire rd_ok    = fin & ~pwrite_in & hit;

  wire shdn     = conf_q[`TSW_CONF_SHDN];
  wire int_mode = conf_q[`TSW_CONF_ALMMODE];
  wire pol_hi   = conf_q[`TSW_CONF_POL];
  wire [1:0] fq = conf_q[`TSW_CONF_FQ_HI:`TSW_CONF_FQ_LO];

  // byte-lane merge for the set points, stored left aligned in [15:7]
  function automatic tsw_setp_t lane_merge(input tsw_setp_t old, input logic [31:0] wd,
                                           input logic [3:0] strb);
    lane_merge = old;
    if (strb[1]) lane_merge[8:1] = wd[15:8];
    if (strb[0]) lane_merge[0]   = wd[`TSW_SETP_LSB];
  endfunction : lane_merge

  wire tsw_setp_t tos_wr   = lane_merge(tos_q, pwdata_in, pstrb_in);
  wire tsw_setp_t thyst_wr = lane_merge(thyst_q, pwdata_in, pstrb_in);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      conf_q  <= `TSW_CONF_RST;
      tos_q   <= `TSW_TOS_RST;
      thyst_q <= `TSW_THYST_RST;
      tidle_q <= `TSW_TIDLE_RST;
    end else if (wr_ok) begin
      if (hit_conf && pstrb_in[0]) conf_q <= pwdata_in[4:0];
      if (hit_tos) tos_q <= tos_wr;
      if (hit_thys) thyst_q <= thyst_wr;
      if (hit_tidl && pstrb_in[0]) tidle_q <= pwdata_in[7:0];
    end
  end

  // address pins: three-flop sync, state accepted once flops two and three agree
  wire [1:0] pin_raw [3];
  logic [1:0] pin_state [3];
  logic [1:0] trit [3];
  assign pin_raw[0] = addr_pin_0_in;
  assign pin_raw[1] = addr_pin_1_in;
  assign pin_raw[2] = addr_pin_2_in;

  for (genvar i = 0; i < 3; i++) begin : g_pin
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] st_q;
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        s1_q <= 2'h0;
        s2_q <= 2'h0;
        s3_q <= 2'h0;
        st_q <= 2'h0;
      end else begin
        s1_q <= pin_raw[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) st_q <= s3_q;
      end
    end
    assign pin_state[i] = st_q;
    // low, high, or floating counts as the third state
    assign trit[i] = pin_state[i][1] ? 2'h2 : {1'b0, pin_state[i][0]};
  end

  wire [6:0] addr_ofs = 7'(trit[0]) + 7'(trit[1]) * 7'h03 + 7'(trit[2]) * 7'h09;
  logic [6:0] target_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) target_q <= `TSW_TARGET_BASE;
    else target_q <= `TSW_TARGET_BASE + addr_ofs;
  end

  // read mux; temp sampled live so a fresh result needs no extra stage
  wire [31:0] st_word = {20'h0, tmo_q, new_q, conv_busy, alarm_act, 1'b0, target_q};
  wire [31:0] rd_mux =
      hit_temp ? {16'h0, temp, 5'h0} :
      hit_conf ? {27'h0, conf_q} :
      hit_thys ? {16'h0, thyst_q, 7'h0} :
      hit_tos  ? {16'h0, tos_q, 7'h0} :
      hit_tidl ? {24'h0, tidle_q} :
      hit_stat ? st_word : 32'h0;

  // bus side effects are edge-bounded; a short or single-lane read ends cleanly
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= acc_1st;
      pslverr_q <= acc_1st & ~hit;
      if (acc_1st) prdata_q <= pwrite_in ? 32'h0 : rd_mux;
    end
  end

  // stall watch: a select held past the time-out without finishing is flagged
  logic [31:0] stall_ms_q;
  wire         stall_hit = (stall_ms_q >= TIMEOUT_MS);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) stall_ms_q <= 32'h0;
    else if (!psel_in || fin) stall_ms_q <= 32'h0;
    else if (ms_tick_q && !stall_hit) stall_ms_q <= stall_ms_q + 32'h1;
  end

  // sticky flags: hardware set beats a read clear in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      new_q <= 1'b0;
      tmo_q <= 1'b0;
    end else begin
      if (conv_done) new_q <= 1'b1;
      else if (rd_ok && hit_temp) new_q <= 1'b0;
      if (stall_hit) tmo_q <= 1'b1;
      else if (rd_ok && hit_stat) tmo_q <= 1'b0;
    end
  end

  tsw_conv u_conv (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .ms_tick_in    (ms_tick_q),
    .shutdown_in   (shdn),
    .period_ms_in  (tidle_q),
    .adc_result_in (adc_result_in),
    .temp_out      (temp),
    .done_out      (conv_done),
    .busy_out      (conv_busy)
  );

  // shutdown entry pulse for the interrupt-mode clear
  logic shdn_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) shdn_q <= 1'b0;
    else shdn_q <= shdn;
  end

  tsw_cmp_if cmp_if ();
  assign cmp_if.temp9    = tsw_setp_t'(temp[10:2]);
  assign cmp_if.tos      = tos_q;
  assign cmp_if.thyst    = thyst_q;
  assign cmp_if.int_mode = int_mode;
  assign cmp_if.fq_sel   = fq;
  assign cmp_if.cmp_stb  = conv_done; // compare once per finished conversion
  assign cmp_if.rd_stb   = rd_ok;
  assign cmp_if.shdn_stb = shdn & ~shdn_q;

  tsw_alarm u_alarm (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .cmp        (cmp_if),
    .active_out (alarm_act)
  );

  // open drain: pin level high means released
  logic alarm_oe_n_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) alarm_oe_n_q <= 1'b1;
    else alarm_oe_n_q <= alarm_act ~^ pol_hi;
  end

  assign prdata_out              = prdata_q;
  assign pready_out              = pready_q;
  assign pslverr_out             = pslverr_q;
  assign target_addr_out         = target_q;
  assign overtemp_alarm_out      = 1'b0;
  assign overtemp_alarm_oe_n_out = alarm_oe_n_q;
endmodule : tsw_top

/* File: tsw_chk.sv */
module tsw_chk
  import tsw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 10,
  parameter int unsigned TIMEOUT_MS  = 2
)(
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [6:0]  target_addr_out,
  input wire logic        overtemp_alarm_out,
  input wire logic        overtemp_alarm_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // first access cycle, answer still pending
  wire acc_wait = psel_in && penable_in && !pready_out;
  wire rd_done  = pready_out && !pwrite_in;

  a_one_wait: assert property (acc_wait |=> pready_out)
    else $error("ready missing after one wait state");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  a_err_unmapped: assert property (acc_wait && paddr_in > 8'h14
    |=> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  a_no_err_mapped: assert property (acc_wait && paddr_in <= 8'h14
    && paddr_in[1:0] == 2'h0 |=> !pslverr_out)
    else $error("mapped access refused");
  a_temp_frac: assert property (rd_done && paddr_in == 8'h00 |-> prdata_out[4:0] == 5'h00)
    else $error("temperature low bits not zero");
  a_setp_frac: assert property (rd_done && paddr_in inside {8'h08, 8'h0C}
    |-> prdata_out[6:0] == 7'h00)
    else $error("set point low bits not zero");
  a_od_data: assert property (overtemp_alarm_out == 1'b0)
    else $error("alarm pin data not low");
  a_addr_span: assert property (target_addr_out inside {[7'h40:7'h5A]})
    else $error("target address outside the 27 codes");
  a_reset_idle: assert property (disable iff (1'b0) rst_in
    |=> overtemp_alarm_oe_n_out && !pready_out)
    else $error("reset state not idle");

  c_unmapped: cover property (pslverr_out);
  c_alarm_on: cover property ($fell(overtemp_alarm_oe_n_out));
  c_temp_read: cover property (rd_done && paddr_in == 8'h00);
endmodule : tsw_chk

bind tsw_top tsw_chk #(.TICK_CYCLES(TICK_CYCLES), .TIMEOUT_MS(TIMEOUT_MS)) chk_u (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .target_addr_out(target_addr_out),
  .overtemp_alarm_out(overtemp_alarm_out), .overtemp_alarm_oe_n_out(overtemp_alarm_oe_n_out)
);

/* File: tsw_apb_mst.sv */
module tsw_apb_mst (
  input  wire logic        clk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [7:0]       paddr_out,
  output logic [31:0]      pwdata_out,
  output logic [3:0]       pstrb_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 8'h00;
    pwdata_out  = 32'h0;
    pstrb_out   = 4'hF;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output int waits);
    int n;
    @(posedge clk_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= wr;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    n = 0;
    // no cap here: a stuck slave is ended by the bench watchdog
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1);
    q     = prdata_in;
    err   = pslverr_in;
    waits = n;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    // released lines do not keep their last value
    paddr_out   <= ~a;
    pwdata_out  <= ~d;
  endtask : xfer

  // select held without access phase, to provoke the bus time-out
  task automatic stall(input int cycles);
    @(posedge clk_in);
    psel_out   <= 1'b1;
    pwrite_out <= 1'b0;
    paddr_out  <= 8'h14;
    repeat (cycles) @(posedge clk_in);
    psel_out   <= 1'b0;
  endtask : stall
endmodule : tsw_apb_mst

/* File: temp_sensor_thermal_watchdog_tb_top.sv */
module temp_sensor_thermal_watchdog_tb_top
  import tsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, alarm, oe_n, er;
  int          nw;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  pstrb;
  logic [6:0]  taddr;
  tsw_temp_t   adc_q = 11'h000;
  logic [1:0]  pin0 = 2'h1;
  logic [1:0]  pin1 = 2'h2;
  logic [1:0]  pin2 = 2'h1;
  int          failures = 0;
  int          compares = 0;
  logic [31:0] rst_tab [4] = '{32'h0, 32'h4B00, 32'h5000, 32'h64};

  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  tsw_top #(.TICK_CYCLES(10), .TIMEOUT_MS(2)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .adc_result_in(adc_q), .addr_pin_0_in(pin0), .addr_pin_1_in(pin1),
    .addr_pin_2_in(pin2), .target_addr_out(taddr), .overtemp_alarm_out(alarm),
    .overtemp_alarm_oe_n_out(oe_n)
  );
  tsw_apb_mst mst_u (
    .clk_in(clk_sys_in), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata), .pstrb_out(pstrb)
  );

  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    mst_u.xfer(1'b0, a, 32'h0, d, er, nw);
    check(32'(nw), 32'h2);
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rv);
    check(rv, exp);
  endtask : rdc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mst_u.xfer(1'b1, a, d, rv, er, nw);
    check(32'(nw), 32'h2);
  endtask : wr

  // back-to-back polling must not hold off the result store
  task automatic next_conv;
    int n;
    n = 0;
    do begin
      rd(8'h14, rv);
      n++;
    end while (rv[10] !== 1'b1 && n < 200);
    check({31'h0, rv[10]}, 32'h1);
    rdc(8'h00, {16'h0, adc_q, 5'h00});
  endtask : next_conv

  task automatic wait_oe(input logic v, input int lim);
    int n;
    n = 0;
    while (oe_n !== v && n < lim) begin
      @(posedge clk_sys_in);
      n++;
    end
    check({31'h0, oe_n}, {31'h0, v});
  endtask : wait_oe

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    complete_run;
  end

  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    for (int i = 0; i < 4; i++) rdc(8'h04 + 8'(4 * i), rst_tab[i]);
    rd(8'h18, rv);
    check({31'h0, er}, 32'h1);
    check({25'h0, taddr}, 32'h50);
    rd(8'h14, rv);
    check({25'h0, rv[6:0]}, 32'h50);
    rd(8'h00, rv);
    check({24'h0, rv[15:8]}, 32'h0);
    wr(8'h10, 32'h1C);
    wr(8'h0C, 32'h0800);
    wr(8'h08, 32'h0600);
    rdc(8'h0C, 32'h0800);
    wr(8'h04, 32'h18);
    adc_q <= 11'h0A0;
    for (int i = 0; i < 6; i++) begin
      next_conv;
      check({31'h0, oe_n}, {31'h0, i != 5});
    end
    rdc(8'h04, 32'h18);
    check({31'h0, oe_n}, 32'h0);
    check({31'h0, alarm}, 32'h0);
    wr(8'h04, 32'h00);
    adc_q <= 11'h000;
    next_conv;
    check({31'h0, oe_n}, 32'h1);
    wr(8'h04, 32'h06);
    adc_q <= 11'h0A0;
    wait_oe(1'b0, 4);
    wait_oe(1'b1, 700);
    rd(8'h10, rv);
    wait_oe(1'b0, 4);
    repeat (700) @(posedge clk_sys_in);
    check({31'h0, oe_n}, 32'h0);
    adc_q <= 11'h000;
    wait_oe(1'b1, 700);
    wr(8'h04, 32'h07);
    wait_oe(1'b0, 4);
    repeat (300) @(posedge clk_sys_in);
    rd(8'h00, rv);
    repeat (600) @(posedge clk_sys_in);
    rd(8'h14, rv);
    check({31'h0, rv[10]}, 32'h0);
    // queue of two: one hot result alone must not trip
    wr(8'h04, 32'h0E);
    adc_q <= 11'h050;
    next_conv;
    check({31'h0, oe_n}, 32'h0);
    mst_u.stall(40);
    rd(8'h14, rv);
    check({31'h0, rv[11]}, 32'h1);
    rd(8'h14, rv);
    check({31'h0, rv[11]}, 32'h0);
    // mid-run reset brings back power-up limits and pin level
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rdc(8'h0C, 32'h5000);
    check({31'h0, oe_n}, 32'h1);
    complete_run;
  end
endmodule : temp_sensor_thermal_watchdog_tb_top
